// *** pkg/mcg_consts.svh ***
// Offsets, field positions, reset values and masks of the module clock gating bank
`ifndef MCG_CONSTS_SVH
`define MCG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define MCG_ADDR_W 12
`define MCG_OFS_RUN_CFG 12'h060
`define MCG_OFS_RUN_GATE 12'h100
`define MCG_OFS_SLEEP_GATE 12'h110
`define MCG_OFS_DEEP_GATE 12'h120

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define MCG_GATE_RESET 32'h0000_0040
`define MCG_GATE_WMASK 32'h1313_0f08
`define MCG_CFG_RESET 32'h0000_0000
`define MCG_CFG_WMASK 32'h0800_0000
`define MCG_ZERO_WORD 32'h0000_0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MCG_BIT_AUTO 27
`define MCG_BIT_WDOG1 28
`define MCG_BIT_CAN_SECOND_CLK_GATE 25
`define MCG_BIT_CAN_FIRST_CLK_GATE 24
`define MCG_BIT_PWM 20
`define MCG_BIT_CONV1 17
`define MCG_BIT_CONV0 16
`define MCG_RATE1_HI 11
`define MCG_RATE1_LO 10
`define MCG_RATE0_HI 9
`define MCG_RATE0_LO 8
`define MCG_BIT_WDOG0 3
`define MCG_RATE_1MSPS 2'h3

// ----------------------------------------------------------------------------
// Gated module indices
// ----------------------------------------------------------------------------
`define MCG_NUM_MODS 7
`define MCG_IDX_WDOG0 0
`define MCG_IDX_WDOG1 1
`define MCG_IDX_CAN_FIRST_CLK_GATE 2
`define MCG_IDX_CAN_SECOND_CLK_GATE 3
`define MCG_IDX_PWM 4
`define MCG_IDX_CONV0 5
`define MCG_IDX_CONV1 6

`endif

// *** pkg/mcg_pkg.sv ***
// Types shared by the module clock gating bank
package mcg_pkg;

  // --------------------------------------------------------------------------
  // Power states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MCG_PWR_RUN = 3'b001,
    MCG_PWR_SLEEP = 3'b010,
    MCG_PWR_DEEP = 3'b100
  } mcg_pwr_type;

  typedef logic [31:0] mcg_word_type;

endpackage : mcg_pkg

// *** pkg/mcg_gate_if.sv ***
// Enables and gated clocks passed between the gating bank and its clock gates
interface mcg_gate_if #(
  parameter int N = 7
);
  logic [N-1:0] en;
  logic [N-1:0] gclk;

  // Bank drives the enables, the gate cells return the clocks
  modport ctrl (output en, input gclk);
  modport gate (input en, output gclk);
endinterface : mcg_gate_if

// *** design/mcg_clk_gate.sv ***
// Glitch-free latch-based clock gate cells, one per gated module
module mcg_clk_gate
  import mcg_pkg::*;
#(
  parameter int N = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enables in, gated clocks out
  mcg_gate_if.gate gif
);

  logic [N-1:0] en_hold;
  logic [N-1:0] en_at_rise;

  // --------------------------------------------------------------------------
  // Gate cells
  // --------------------------------------------------------------------------
  // The latch is open only while clk is low, so the enable cannot change
  // during the high phase and no clipped pulse leaves the cell
  for (genvar i = 0; i < N; i++) begin : g_cell
    // Reset also waits for the low phase, so a reset in a high phase lets the pulse finish
    always_latch begin
      if (!clk) begin
        en_hold[i] = rst_n ? gif.en[i] : 1'b0;
      end
    end
    assign gif.gclk[i] = clk & en_hold[i];
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_hold_match;
    @(posedge clk) disable iff (!rst_n)
      en_hold == gif.en;
  endproperty
  a_hold_match: assert property (p_hold_match) else $error("gate latch out of step");

  // Latch output as the high phase begins; it must not move before the fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_at_rise <= '0;
    end else begin
      en_at_rise <= en_hold;
    end
  end

  property p_hold_steady;
    @(negedge clk) disable iff (!rst_n)
      en_hold == en_at_rise;
  endproperty
  a_hold_steady: assert property (p_hold_steady) else $error("enable moved in high phase");

endmodule : mcg_clk_gate

// *** design/mcg_bank.sv ***
// Module clock gating bank: run, sleep and deep sleep gating registers
// Notes on behaviour
// - A set gating bit clocks its module; a clear bit stops its clock.
// - Accesses to a module whose clock is off get a bus fault.
// - All gating bits are zero after reset, every module unclocked.
// - Separate run, sleep and deep sleep copies govern their own power state.
// - Sleep and deep sleep copies apply only while automatic gating is selected.
// - Bit 28 gates the second watchdog, bit 3 the first.
// - Bit 25 gates the second CAN controller, bit 24 the first.
// - Bit 20 gates the PWM unit.
// - Bit 17 gates the second converter, bit 16 the first.
// - Bits 11:10 hold the second converter rate; code 3 is one megasample.
// - Bits 9:8 hold the first converter rate; code 3 is one megasample.
// - Reserved bits read zero; software preserves them and ignores them.
`include "mcg_consts.svh"

module mcg_bank
  import mcg_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [`MCG_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Power state from the sequencer
  input wire mcg_pwr_type pwr_state,
  // Gated modules
  input wire logic [`MCG_NUM_MODS-1:0] mod_req,
  output logic [`MCG_NUM_MODS-1:0] mod_fault,
  output logic [`MCG_NUM_MODS-1:0] mod_clk,
  output logic [`MCG_NUM_MODS-1:0] mod_clk_en,
  // Converter sample rates in force and the automatic gating select
  output logic [1:0] converter_first_rate_sel,
  output logic [1:0] converter_second_rate_sel,
  output logic auto_sleep_gating_select
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam int NM = `MCG_NUM_MODS;
  localparam int GATE_POS [NM] = '{
    `MCG_BIT_WDOG0, `MCG_BIT_WDOG1, `MCG_BIT_CAN_FIRST_CLK_GATE, `MCG_BIT_CAN_SECOND_CLK_GATE,
    `MCG_BIT_PWM, `MCG_BIT_CONV0, `MCG_BIT_CONV1
  };

  mcg_word_type run_clock_gate_bank0;
  mcg_word_type sleep_clock_gate_bank0;
  mcg_word_type deep_sleep_clock_gate_bank0;
  mcg_word_type run_clock_config;
  mcg_word_type sel_word;
  mcg_word_type rd_mux;
  mcg_word_type wr_gate_val;
  mcg_word_type wr_cfg_val;
  logic [NM-1:0] next_clk_en;
  logic hit_run;
  logic hit_sleep;
  logic hit_deep;
  logic hit_cfg;
  logic hit_gate;
  logic auto_sel;
  logic watchdog_first_clk_gate;
  logic watchdog_second_clk_gate;
  logic can_first_clk_gate;
  logic can_second_clk_gate;
  logic converter_first_clk_gate;
  logic converter_second_clk_gate;

  mcg_gate_if #(.N(NM)) gate_bus ();

  // --------------------------------------------------------------------------
  // Address decode and write values
  // --------------------------------------------------------------------------
  // Only writable fields are stored; reserved bits can never hold a one
  assign hit_run = (addr == `MCG_OFS_RUN_GATE);
  assign hit_sleep = (addr == `MCG_OFS_SLEEP_GATE);
  assign hit_deep = (addr == `MCG_OFS_DEEP_GATE);
  assign hit_cfg = (addr == `MCG_OFS_RUN_CFG);
  assign hit_gate = hit_run | hit_sleep | hit_deep;
  assign wr_gate_val = wdata & `MCG_GATE_WMASK;
  assign wr_cfg_val = wdata & `MCG_CFG_WMASK;
  assign auto_sel = run_clock_config[`MCG_BIT_AUTO];

  // --------------------------------------------------------------------------
  // Gating registers
  // --------------------------------------------------------------------------
  // The reset image is masked, so every gating and rate bit starts at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_clock_gate_bank0 <= `MCG_GATE_RESET & `MCG_GATE_WMASK;
      sleep_clock_gate_bank0 <= `MCG_GATE_RESET & `MCG_GATE_WMASK;
      deep_sleep_clock_gate_bank0 <= `MCG_GATE_RESET & `MCG_GATE_WMASK;
    end else if (ce && wr) begin
      if (hit_run) begin
        run_clock_gate_bank0 <= wr_gate_val;
      end
      if (hit_sleep) begin
        sleep_clock_gate_bank0 <= wr_gate_val;
      end
      if (hit_deep) begin
        deep_sleep_clock_gate_bank0 <= wr_gate_val;
      end
    end
  end

  // Run-mode clock configuration, holding only the automatic gating select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_clock_config <= `MCG_CFG_RESET;
    end else if (ce && wr && hit_cfg) begin
      run_clock_config <= wr_cfg_val;
    end
  end

  // --------------------------------------------------------------------------
  // Bank selection
  // --------------------------------------------------------------------------
  // Without automatic gating the run copy stays in force in every state;
  // an illegal state code falls back to the run copy so nothing stops
  always_comb begin
    sel_word = run_clock_gate_bank0;
    if (auto_sel) begin
      unique case (pwr_state)
        MCG_PWR_RUN: sel_word = run_clock_gate_bank0;
        MCG_PWR_SLEEP: sel_word = sleep_clock_gate_bank0;
        MCG_PWR_DEEP: sel_word = deep_sleep_clock_gate_bank0;
        default: sel_word = run_clock_gate_bank0;
      endcase
    end
  end

  // Field picks of the selected copy
  assign watchdog_first_clk_gate = sel_word[`MCG_BIT_WDOG0];
  assign watchdog_second_clk_gate = sel_word[`MCG_BIT_WDOG1];
  assign can_first_clk_gate = sel_word[`MCG_BIT_CAN_FIRST_CLK_GATE];
  assign can_second_clk_gate = sel_word[`MCG_BIT_CAN_SECOND_CLK_GATE];
  assign converter_first_clk_gate = sel_word[`MCG_BIT_CONV0];
  assign converter_second_clk_gate = sel_word[`MCG_BIT_CONV1];

  // One enable per gated module, taken from its bit position
  for (genvar i = 0; i < NM; i++) begin : g_en
    assign next_clk_en[i] = sel_word[GATE_POS[i]];
  end

  // --------------------------------------------------------------------------
  // Enable and rate outputs
  // --------------------------------------------------------------------------
  // Registering the enables keeps decode glitches away from the gate latches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_clk_en <= '0;
      converter_first_rate_sel <= '0;
      converter_second_rate_sel <= '0;
      auto_sleep_gating_select <= 1'b0;
    end else if (ce) begin
      mod_clk_en <= next_clk_en;
      converter_first_rate_sel <= sel_word[`MCG_RATE0_HI:`MCG_RATE0_LO];
      converter_second_rate_sel <= sel_word[`MCG_RATE1_HI:`MCG_RATE1_LO];
      auto_sleep_gating_select <= auto_sel;
    end
  end

  // --------------------------------------------------------------------------
  // Clock gates and bus fault
  // --------------------------------------------------------------------------
  // Rate codes other than the one-megasample code are reserved; they are stored
  // and passed on unchanged, the converter decides what to do with them
  assign gate_bus.en = mod_clk_en;
  assign mod_clk = gate_bus.gclk;
  assign mod_fault = mod_req & ~mod_clk_en;

  mcg_clk_gate #(.N(NM)) u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .gif(gate_bus)
  );

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Unmapped addresses read zero; read data stand for one cycle only
  always_comb begin
    rd_mux = `MCG_ZERO_WORD;
    if (hit_run) begin
      rd_mux = run_clock_gate_bank0;
    end else if (hit_sleep) begin
      rd_mux = sleep_clock_gate_bank0;
    end else if (hit_deep) begin
      rd_mux = deep_sleep_clock_gate_bank0;
    end else if (hit_cfg) begin
      rd_mux = run_clock_config;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `MCG_ZERO_WORD;
    end else if (ce) begin
      rdata <= rd ? rd_mux : `MCG_ZERO_WORD;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // A clearing write to the run copy, then one settled cycle in run state
  sequence s_run_cleared;
    (ce && wr && hit_run && (wr_gate_val == `MCG_ZERO_WORD) && !auto_sel)
      ##1 (ce && pwr_state == MCG_PWR_RUN);
  endsequence

  property p_fault_after_clear;
    @(posedge clk) disable iff (!rst_n)
      s_run_cleared |=> (mod_fault == mod_req);
  endproperty
  a_fault_after_clear: assert property (p_fault_after_clear) else $error("no fault when off");

  property p_reset_off;
    @(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> (mod_clk_en == '0) && (rdata == `MCG_ZERO_WORD);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enables set after reset");

  property p_no_auto_uses_run;
    @(posedge clk) disable iff (!rst_n)
      (ce && !auto_sel && pwr_state != MCG_PWR_RUN)
        |=> (mod_clk_en[`MCG_IDX_CONV0] == $past(run_clock_gate_bank0[`MCG_BIT_CONV0]))
          && (mod_clk_en[`MCG_IDX_CONV1] == $past(run_clock_gate_bank0[`MCG_BIT_CONV1]));
  endproperty
  a_no_auto_uses_run: assert property (p_no_auto_uses_run) else $error("sleep copy used");

  property p_run_wdog;
    @(posedge clk) disable iff (!rst_n)
      (ce && pwr_state == MCG_PWR_RUN)
        |=> (mod_clk_en[`MCG_IDX_WDOG0] == $past(run_clock_gate_bank0[`MCG_BIT_WDOG0]))
          && (mod_clk_en[`MCG_IDX_WDOG1] == $past(run_clock_gate_bank0[`MCG_BIT_WDOG1]));
  endproperty
  a_run_wdog: assert property (p_run_wdog) else $error("watchdog enable wrong");

  property p_sleep_can;
    @(posedge clk) disable iff (!rst_n)
      (ce && auto_sel && pwr_state == MCG_PWR_SLEEP)
        |=> (mod_clk_en[`MCG_IDX_CAN_FIRST_CLK_GATE] == $past(sleep_clock_gate_bank0[`MCG_BIT_CAN_FIRST_CLK_GATE]))
          && (mod_clk_en[`MCG_IDX_CAN_SECOND_CLK_GATE] == $past(sleep_clock_gate_bank0[`MCG_BIT_CAN_SECOND_CLK_GATE]));
  endproperty
  a_sleep_can: assert property (p_sleep_can) else $error("sleep CAN enable wrong");

  property p_deep_pwm;
    @(posedge clk) disable iff (!rst_n)
      (ce && auto_sel && pwr_state == MCG_PWR_DEEP)
        |=> mod_clk_en[`MCG_IDX_PWM] == $past(deep_sleep_clock_gate_bank0[`MCG_BIT_PWM]);
  endproperty
  a_deep_pwm: assert property (p_deep_pwm) else $error("deep PWM enable wrong");

  property p_rate_read;
    @(posedge clk) disable iff (!rst_n)
      (ce && rd && hit_run)
        |=> (rdata[`MCG_RATE1_HI:`MCG_RATE0_LO] ==
             $past(run_clock_gate_bank0[`MCG_RATE1_HI:`MCG_RATE0_LO]));
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate field readback wrong");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n)
      (ce && rd && hit_gate) |=> ((rdata & ~`MCG_GATE_WMASK) == `MCG_ZERO_WORD);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

  // Each high phase of a gated clock follows the enable held in the low phase before it
  property p_clk_follows_en;
    @(negedge clk) disable iff (!rst_n)
      mod_clk == $past(mod_clk_en);
  endproperty
  a_clk_follows_en: assert property (p_clk_follows_en) else $error("gated clock wrong");

  property p_sleep_write;
    @(posedge clk) disable iff (!rst_n)
      (ce && wr && hit_sleep)
        |=> sleep_clock_gate_bank0 == ($past(wdata) & `MCG_GATE_WMASK);
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("sleep copy write lost");

  property p_deep_conv;
    @(posedge clk) disable iff (!rst_n)
      (ce && auto_sel && pwr_state == MCG_PWR_DEEP)
        |=> (mod_clk_en[`MCG_IDX_CONV0] == $past(deep_sleep_clock_gate_bank0[`MCG_BIT_CONV0]))
          && (mod_clk_en[`MCG_IDX_CONV1] == $past(deep_sleep_clock_gate_bank0[`MCG_BIT_CONV1]));
  endproperty
  a_deep_conv: assert property (p_deep_conv) else $error("deep converter enable wrong");

  property p_run_rate;
    @(posedge clk) disable iff (!rst_n)
      (ce && !auto_sel)
        |=> (converter_second_rate_sel ==
             $past(run_clock_gate_bank0[`MCG_RATE1_HI:`MCG_RATE1_LO]));
  endproperty
  a_run_rate: assert property (p_run_rate) else $error("second rate wrong");

  property p_sleep_rate;
    @(posedge clk) disable iff (!rst_n)
      (ce && auto_sel && pwr_state == MCG_PWR_SLEEP)
        |=> (converter_first_rate_sel ==
             $past(sleep_clock_gate_bank0[`MCG_RATE0_HI:`MCG_RATE0_LO]));
  endproperty
  a_sleep_rate: assert property (p_sleep_rate) else $error("first rate wrong");

endmodule : mcg_bank

// *** dv/mcg_mod_model.sv ***
// Model of the gated modules: counts clock pulses, flags short pulses, raises accesses
`include "mcg_consts.svh"

module mcg_mod_model
  import mcg_pkg::*;
(
  // Gated clocks from the bank
  input wire logic [`MCG_NUM_MODS-1:0] mod_clk,
  // Accesses the bench wants made
  input wire logic [`MCG_NUM_MODS-1:0] want_req,
  output logic [`MCG_NUM_MODS-1:0] mod_req,
  // Observations
  output logic [8*`MCG_NUM_MODS-1:0] pulse_cnt,
  output int glitch_cnt
);
  timeunit 1ns;
  timeprecision 100ps;

  int short_cnt [`MCG_NUM_MODS];

  // A module only requests while the bench asks it to
  assign mod_req = want_req;

  // Per module: pulse counter and a check that no high phase is cut short
  for (genvar gi = 0; gi < `MCG_NUM_MODS; gi++) begin : g_mod
    realtime t_rise = 0.0;
    initial begin
      pulse_cnt[gi*8 +: 8] = 8'h00;
      short_cnt[gi] = 0;
    end
    always @(posedge mod_clk[gi]) begin
      pulse_cnt[gi*8 +: 8] <= pulse_cnt[gi*8 +: 8] + 8'h01;
      t_rise = $realtime;
    end
    // Half period is 12.5 ns; a high phase under 12 ns reached the module as a glitch
    always @(negedge mod_clk[gi]) begin
      if (t_rise > 0.0 && ($realtime - t_rise) < 12.0) begin
        short_cnt[gi] <= short_cnt[gi] + 1;
      end
    end
  end

  // Total of short pulses over all modules
  always_comb begin
    glitch_cnt = 0;
    for (int i = 0; i < `MCG_NUM_MODS; i++) begin
      glitch_cnt = glitch_cnt + short_cnt[i];
    end
  end
endmodule : mcg_mod_model

// *** dv/tb.sv ***
// Self-checking testbench of the module clock gating bank
`include "mcg_consts.svh"

module tb
  import mcg_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [`MCG_ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  mcg_pwr_type pwr_state = MCG_PWR_RUN;
  logic [`MCG_NUM_MODS-1:0] want_req = '1;
  logic [`MCG_NUM_MODS-1:0] mod_req, mod_fault, mod_clk, mod_clk_en;
  logic [1:0] rate0, rate1;
  logic auto_sel;
  logic [8*`MCG_NUM_MODS-1:0] pulse_cnt;
  int glitch_cnt;
  int err_total = 0;
  int n_tests = 0;
  // Register bit of each gated module, in module index order
  int bitpos [`MCG_NUM_MODS] = '{`MCG_BIT_WDOG0, `MCG_BIT_WDOG1, `MCG_BIT_CAN_FIRST_CLK_GATE,
    `MCG_BIT_CAN_SECOND_CLK_GATE, `MCG_BIT_PWM, `MCG_BIT_CONV0, `MCG_BIT_CONV1};

  initial begin
    forever #12.5 clk = ~clk;
  end

  mcg_bank mcg_bank_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pwr_state(pwr_state), .mod_req(mod_req),
    .mod_fault(mod_fault), .mod_clk(mod_clk), .mod_clk_en(mod_clk_en),
    .converter_first_rate_sel(rate0), .converter_second_rate_sel(rate1),
    .auto_sleep_gating_select(auto_sel));

  mcg_mod_model mcg_mod_model_inst (.mod_clk(mod_clk), .want_req(want_req), .mod_req(mod_req),
    .pulse_cnt(pulse_cnt), .glitch_cnt(glitch_cnt));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle write strobe; taken at the second edge
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(name, rdata, exp);
  endtask : rd_chk

  // Enables follow one edge after the register; leave margin for the latch
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle

  // Eight clock edges must give eight pulses to enabled modules, none to others
  task automatic pulses(input logic [6:0] en);
    logic [8*`MCG_NUM_MODS-1:0] cnt_start;
    cnt_start = pulse_cnt;
    repeat (8) @(posedge clk);
    #1;
    for (int i = 0; i < `MCG_NUM_MODS; i++) begin
      chk("pulses", {24'h0, pulse_cnt[i*8 +: 8] - cnt_start[i*8 +: 8]}, en[i] ? 32'h8 : 32'h0);
    end
  endtask : pulses

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Everything starts unclocked and reads zero
    chk("en_rst", {25'h0, mod_clk_en}, 32'h0);
    chk("fault_rst", {25'h0, mod_fault}, 32'h7f);
    rd_chk("run_rst", `MCG_OFS_RUN_GATE, 32'h0);
    rd_chk("sleep_rst", `MCG_OFS_SLEEP_GATE, 32'h0);
    rd_chk("deep_rst", `MCG_OFS_DEEP_GATE, 32'h0);
    pulses(7'h00);
    // Reserved bits stay zero in every copy
    reg_wr(`MCG_OFS_RUN_GATE, 32'hffff_ffff);
    reg_wr(`MCG_OFS_SLEEP_GATE, 32'hffff_ffff);
    reg_wr(`MCG_OFS_DEEP_GATE, 32'hffff_ffff);
    rd_chk("run_all", `MCG_OFS_RUN_GATE, 32'h1313_0f08);
    rd_chk("sleep_all", `MCG_OFS_SLEEP_GATE, 32'h1313_0f08);
    rd_chk("deep_all", `MCG_OFS_DEEP_GATE, 32'h1313_0f08);
    rd_chk("cfg_rst", `MCG_OFS_RUN_CFG, 32'h0);
    // One gating bit at a time: clock, enable and fault of that module only
    for (int i = 0; i < `MCG_NUM_MODS; i++) begin
      reg_wr(`MCG_OFS_RUN_GATE, 32'h1 << bitpos[i]);
      settle();
      chk("en_map", {25'h0, mod_clk_en}, 32'h1 << i);
      chk("fault_map", {25'h0, mod_fault}, ~(32'h1 << i) & 32'h7f);
      pulses(7'h1 << i);
    end
    // Only the maximum rate code and code 0 are ever programmed
    reg_wr(`MCG_OFS_RUN_GATE, 32'h0000_0f00);
    settle();
    chk("rate1", {30'h0, rate1}, 32'h3);
    chk("rate0", {30'h0, rate0}, 32'h3);
    reg_wr(`MCG_OFS_RUN_GATE, 32'h0000_0300);
    settle();
    chk("rate1_off", {30'h0, rate1}, 32'h0);
    chk("rate0_on", {30'h0, rate0}, 32'h3);
    // Unmapped place: write ignored, read zero
    reg_wr(12'h104, 32'hffff_ffff);
    rd_chk("unmapped", 12'h104, 32'h0);
    // Sleep copies are ignored until automatic gating is selected
    reg_wr(`MCG_OFS_RUN_GATE, 32'h0);
    reg_wr(`MCG_OFS_SLEEP_GATE, 32'h1 << `MCG_BIT_WDOG0);
    reg_wr(`MCG_OFS_DEEP_GATE, 32'h1 << `MCG_BIT_CONV0);
    @(posedge clk);
    pwr_state <= MCG_PWR_SLEEP;
    settle();
    chk("en_noauto", {25'h0, mod_clk_en}, 32'h0);
    reg_wr(`MCG_OFS_RUN_CFG, 32'hffff_ffff);
    rd_chk("cfg_rd", `MCG_OFS_RUN_CFG, 32'h0800_0000);
    settle();
    chk("auto", {31'h0, auto_sel}, 32'h1);
    chk("en_sleep", {25'h0, mod_clk_en}, 32'h1);
    pulses(7'h01);
    @(posedge clk);
    pwr_state <= MCG_PWR_DEEP;
    settle();
    chk("en_deep", {25'h0, mod_clk_en}, 32'h20);
    chk("fault_deep", {25'h0, mod_fault}, 32'h5f);
    // Modules that make no access get no fault; of those that access, only the clocked one goes free
    @(posedge clk);
    want_req <= 7'h2a;
    @(negedge clk);
    chk("fault_part", {25'h0, mod_fault}, 32'h0a);
    @(posedge clk);
    want_req <= '1;
    @(posedge clk);
    pwr_state <= MCG_PWR_RUN;
    settle();
    chk("en_run", {25'h0, mod_clk_en}, 32'h0);
    // Frozen block takes no write
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(`MCG_OFS_RUN_GATE, 32'h1 << `MCG_BIT_PWM);
    ce <= 1'b1;
    rd_chk("frozen", `MCG_OFS_RUN_GATE, 32'h0);
    // Second reset in mid-run while a gated clock runs; the gate lets that pulse finish
    @(posedge clk);
    pwr_state <= MCG_PWR_SLEEP;
    settle();
    chk("en_pre_rst2", {25'h0, mod_clk_en}, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("en_rst2", {25'h0, mod_clk_en}, 32'h0);
    pulses(7'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("sleep_rst2", `MCG_OFS_SLEEP_GATE, 32'h0);
    rd_chk("cfg_rst2", `MCG_OFS_RUN_CFG, 32'h0);
    chk("glitches", glitch_cnt, 32'h0);
    give_verdict();
  end
endmodule : tb
